// ### pdfr_pkg.sv
// pdfr_pkg: constants, types and coding helpers for the packet framer
// ==========================================================
// Functional notes
// R1: send preamble, start set, payload with header, CRC, then end code, in order
// R2: every framed bit, preamble too, goes to the biphase-mark line coder
// R3: preamble is 64 alternating bits, first a zero, last a one
// R4: preamble is sent raw; everything after it is 4b5b coded
// R5: ordinary start set is sync1, sync1, sync1, sync2
// R6: single-prime start set is sync1, sync1, sync3, sync3
// R7: double-prime start set is sync1, sync3, sync1, sync3
// R8: recognise both debug start sets, only report them
// R9: ports take ordinary packets; transmissions without valid start set are dropped
// R10: cable plugs never send nor accept ordinary packets
// R11: single-prime cable plug talks only with single-prime packets
// R12: single-prime capable port accepts ordinary and single-prime, drops others
// R13: upstream port under explicit contract neither sends nor accepts single-prime
// R14: sink without explicit contract neither sends nor accepts single-prime
// R15: double-prime cable plug accepts only double-prime packets
// R16: double-prime port needs single-prime; one frame at a time avoids collisions
// R17: payload nibbles use the 4b5b hex data symbols
// R18: CRC follows the payload directly and is 4b5b coded
// R19: one end code right after CRC; may also cut a packet short
// R20: after end code check residual; deliver good packet, drop bad whole
// R21: 32-bit CRC, polynomial 04C11DB7, preset FFFFFFFF
// R22: CRC covers payload bytes only, bit 0 to bit 7, from byte 0
// R23: sent CRC is inverted remainder; good packet leaves residual C704DD7B
// R24: CRC register bit n goes to field bit 31 minus n
// R25: K-code symbols fixed; reserved symbols are errors
// R26: a start set is valid when at least three of four codes match; the receiver misses a set whose first code is corrupted
// R27: a symbol decoding error drops the packet like a CRC error
// R28: report start-set variant of delivered packets and each discard; the code updates RX_SOP only for delivered packets and debug-set discards
// R29: low nibble symbol before high; each symbol sent LSB first
package pdfr_pkg;

	// ==========================================================
	// timing and sizes
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_TIME_NS = 3334;
	localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int PRE_BITS = 64;
	localparam int SOP_LEN = 4;
	localparam int SYM_BITS = 5;
	localparam int CRC_NIBS = 8;
	localparam int CRC_BYTES = 4;
	localparam int NSETS = 7;

	// ==========================================================
	// CRC
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_PRESET = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_RESIDUAL = 32'hC704DD7B;

	// ==========================================================
	// line symbols
	localparam logic [4:0] K_SYNC1 = 5'h18;
	localparam logic [4:0] K_SYNC2 = 5'h11;
	localparam logic [4:0] K_SYNC3 = 5'h06;
	localparam logic [4:0] K_RST1 = 5'h07;
	localparam logic [4:0] K_RST2 = 5'h19;
	localparam logic [4:0] K_EOP = 5'h0D;
	localparam logic [4:0] DATA_SYM [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

	typedef enum logic [2:0] {
		PDFR_SOP, PDFR_SOP_P, PDFR_SOP_PP, PDFR_DBG_P, PDFR_DBG_PP, PDFR_HARD_RST, PDFR_CABLE_RST, PDFR_NONE
	} pdfr_sop_e;

	// code k of a set sits at [5k+:5], first code in the low bits
	localparam logic [19:0] SOP_SETS [NSETS] = '{
		{K_SYNC2, K_SYNC1, K_SYNC1, K_SYNC1},
		{K_SYNC3, K_SYNC3, K_SYNC1, K_SYNC1},
		{K_SYNC3, K_SYNC1, K_SYNC3, K_SYNC1},
		{K_SYNC3, K_RST2, K_RST2, K_SYNC1},
		{K_SYNC2, K_SYNC3, K_RST2, K_SYNC1},
		{K_RST2, K_RST1, K_RST1, K_RST1},
		{K_SYNC3, K_RST1, K_SYNC1, K_RST1}};

	typedef struct packed {
		logic is_cable;
		logic cable_dprime;
		logic prime_en;
		logic dprime_en;
		logic is_ufp;
		logic is_sink;
		logic contract_explicit;
	} pdfr_cfg_s;

	// ==========================================================
	// helpers
	function automatic logic [31:0] pdfr_crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h00000000); // R21 R22
		end
		return r;
	endfunction : pdfr_crc_byte

	function automatic logic [31:0] pdfr_crc_field(input logic [31:0] c);
		logic [31:0] f;
		for (int i = 0; i < 32; i++) begin
			f[31-i] = ~c[i]; // R23 R24
		end
		return f;
	endfunction : pdfr_crc_field

	function automatic logic [4:0] pdfr_sop_sym(input pdfr_sop_e t, input logic [1:0] k);
		logic [19:0] s;
		s = (t == PDFR_NONE) ? 20'h00000 : SOP_SETS[int'(t)];
		return s[SYM_BITS*int'(k) +: SYM_BITS];
	endfunction : pdfr_sop_sym

	// bit 4 flags a symbol that is not hex data
	function automatic logic [4:0] pdfr_dec(input logic [4:0] s);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 0; i < 16; i++) begin
			if (DATA_SYM[i] == s) begin
				r = {1'b0, 4'(i)};
			end
		end
		return r;
	endfunction : pdfr_dec

	function automatic pdfr_sop_e pdfr_classify(input logic [19:0] got);
		pdfr_sop_e r;
		int hits;
		r = PDFR_NONE;
		for (int t = NSETS - 1; t >= 0; t--) begin
			hits = 0;
			for (int k = 0; k < SOP_LEN; k++) begin
				hits += int'(got[SYM_BITS*k +: SYM_BITS] == SOP_SETS[t][SYM_BITS*k +: SYM_BITS]);
			end
			if (hits >= 3) begin
				r = pdfr_sop_e'(3'(t)); // R26
			end
		end
		return r;
	endfunction : pdfr_classify

	// one policy for both directions: what may be sent is what may be taken
	function automatic logic pdfr_accept(input pdfr_cfg_s c, input pdfr_sop_e t);
		logic prime_ok;
		prime_ok = c.prime_en && !(c.is_ufp && c.contract_explicit) && !(c.is_sink && !c.contract_explicit); // R13 R14
		if (c.is_cable) begin
			return t == (c.cable_dprime ? PDFR_SOP_PP : PDFR_SOP_P); // R10 R11 R15
		end
		return t == PDFR_SOP || (t == PDFR_SOP_P && prime_ok) || (t == PDFR_SOP_PP && prime_ok && c.dprime_en); // R9 R12 R16
	endfunction : pdfr_accept

endpackage : pdfr_pkg

// ### pdfr_packet_framer.sv
// pdfr_packet_framer: transmit framer, receive checker and the payload FIFO
// ==========================================================
// payload FIFO
module pdfr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two, at least 2");
	end

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem_q[rp_q];

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(pop);
			cnt_q <= cnt_d;
			in_ready <= cnt_d != (AW+1)'(DEPTH);
			out_valid <= cnt_d != '0;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule : pdfr_fifo

// ==========================================================
// framer top
module pdfr_packet_framer import pdfr_pkg::*; #(
	parameter int BIT_DIV = BIT_CYCLES,
	parameter int FIFO_DEPTH = 4,
	parameter int RX_BYTES = 32
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// role and contract state
	input wire pdfr_cfg_s CFG,
	// transmit request
	input wire logic TX_START,
	input wire pdfr_sop_e TX_SOP,
	input wire logic TX_ABORT,
	// transmit payload
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic TX_LAST,
	output logic TX_READY,
	// transmit status
	output logic TX_DONE,
	output logic TX_REFUSED,
	output logic TX_CUT,
	// toward the line coder
	output logic LINE_TX_EN,
	output logic LINE_TX_STB,
	output logic LINE_TX_BIT,
	// from the line decoder
	input wire logic LINE_RX_ACTIVE,
	input wire logic LINE_RX_STB,
	input wire logic LINE_RX_BIT,
	// delivery to the protocol layer
	output logic RX_VALID,
	output logic [7:0] RX_DATA,
	output logic RX_LAST,
	output pdfr_sop_e RX_SOP,
	output logic RX_DISCARD,
	output logic RX_DEBUG
);
	localparam int DW = $clog2(BIT_DIV);
	localparam int NW = $clog2(RX_BYTES + 1);
	localparam int AW = $clog2(RX_BYTES);

	if (BIT_DIV < 2 || RX_BYTES <= CRC_BYTES) begin : g_bad_param
		$error("bit divider below 2 or receive buffer too small");
	end

	typedef enum {T_IDLE, T_PRE, T_SOP, T_DATA, T_CRC, T_EOP, T_TAIL} pdfr_tx_e;
	typedef enum {R_HUNT, R_SOP, R_DATA, R_DROP, R_OUT} pdfr_rx_e;

	// ==========================================================
	// bit-rate enable
	pdfr_tx_e tx_st_q;
	pdfr_tx_e tx_st_d;
	logic [DW-1:0] div_q;
	logic bit_en;

	assign bit_en = div_q == DW'(BIT_DIV - 1);

	// restarted while idle so the first bit is a full bit time after start
	always_ff @(posedge CLOCK) begin
		if (RESET || bit_en || tx_st_q == T_IDLE) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// ==========================================================
	// payload FIFO
	logic f_valid;
	logic f_pop;
	logic [8:0] f_data;

	pdfr_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLOCK),
		.rst(RESET),
		.in_valid(TX_VALID),
		.in_ready(TX_READY),
		.in_data({TX_LAST, TX_DATA}),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	// ==========================================================
	// transmit sequencer
	pdfr_sop_e tx_sop_q;
	logic [5:0] pre_q;
	logic [5:0] pre_d;
	logic [4:0] sym_q;
	logic [4:0] sym_d;
	logic [2:0] bit_q;
	logic [2:0] bit_d;
	logic [2:0] idx_q;
	logic [2:0] idx_d;
	logic [2:0] nidx;
	logic hi_q;
	logic hi_d;
	logic [8:0] byte_q;
	logic [8:0] byte_d;
	logic [31:0] crc_q;
	logic [31:0] crc_d;
	logic [31:0] field_w;
	logic abort_q;
	logic tx_ok;
	logic fetch;
	logic sym_end;
	logic lbit_d;
	logic stb_d;
	logic done_d;
	logic cut_d;

	assign tx_ok = pdfr_accept(CFG, TX_SOP); // R10 R13 R14 R16
	assign field_w = pdfr_crc_field(crc_q); // R23 R24
	assign nidx = idx_q + 3'h1;
	assign sym_end = bit_en && bit_q == 3'(SYM_BITS - 1);

	always_comb begin
		tx_st_d = tx_st_q;
		pre_d = pre_q;
		sym_d = sym_q;
		bit_d = bit_q;
		idx_d = idx_q;
		hi_d = hi_q;
		byte_d = byte_q;
		crc_d = crc_q;
		f_pop = 1'b0;
		fetch = 1'b0;
		lbit_d = LINE_TX_BIT;
		stb_d = 1'b0;
		done_d = 1'b0;
		cut_d = 1'b0;
		case (tx_st_q)
			T_IDLE: begin
				// single transmitter: one frame at a time, no overlap of variants
				if (TX_START && tx_ok) begin // R16
					tx_st_d = T_PRE;
					pre_d = '0;
					crc_d = CRC_PRESET; // R21
				end
			end
			T_PRE: begin
				if (bit_en) begin
					stb_d = 1'b1;
					lbit_d = pre_q[0]; // R3 R4
					pre_d = pre_q + 6'h01;
					if (pre_q == 6'(PRE_BITS - 1)) begin
						tx_st_d = T_SOP; // R1
						idx_d = '0;
						bit_d = '0;
						sym_d = pdfr_sop_sym(tx_sop_q, 2'h0); // R5 R6 R7
					end
				end
			end
			T_TAIL: begin
				// holds the frame open for the last bit's time
				if (bit_en) begin
					tx_st_d = T_IDLE;
					done_d = 1'b1;
				end
			end
			default: begin
				if (bit_en) begin
					stb_d = 1'b1;
					lbit_d = sym_q[bit_q]; // R2 R29
					bit_d = bit_q + 3'h1;
				end
				if (sym_end) begin
					bit_d = '0;
					if (tx_st_q == T_EOP) begin
						tx_st_d = T_TAIL; // R19
					end else if (abort_q) begin
						tx_st_d = T_EOP; // R19
						sym_d = K_EOP;
						cut_d = 1'b1;
					end else begin
						case (tx_st_q)
							T_SOP: begin
								if (idx_q != 3'(SOP_LEN - 1)) begin
									idx_d = nidx;
									sym_d = pdfr_sop_sym(tx_sop_q, nidx[1:0]);
								end else begin
									fetch = 1'b1;
								end
							end
							T_DATA: begin
								if (hi_q) begin
									sym_d = DATA_SYM[byte_q[7:4]]; // R17 R29
									hi_d = 1'b0;
								end else if (byte_q[8]) begin
									tx_st_d = T_CRC; // R18
									idx_d = '0;
									sym_d = DATA_SYM[field_w[3:0]];
								end else begin
									fetch = 1'b1;
								end
							end
							default: begin
								if (idx_q == 3'(CRC_NIBS - 1)) begin
									tx_st_d = T_EOP; // R19
									sym_d = K_EOP;
								end else begin
									idx_d = nidx;
									sym_d = DATA_SYM[field_w[{nidx, 2'b00} +: 4]]; // R18
								end
							end
						endcase
					end
				end
				if (fetch) begin
					if (f_valid) begin
						f_pop = 1'b1;
						byte_d = f_data;
						crc_d = pdfr_crc_byte(crc_q, f_data[7:0]); // R22
						sym_d = DATA_SYM[f_data[3:0]]; // R17 R29
						hi_d = 1'b1;
						tx_st_d = T_DATA;
					end else begin
						// payload ran dry: cut the frame short
						tx_st_d = T_EOP; // R19
						sym_d = K_EOP;
						cut_d = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			tx_st_q <= T_IDLE;
			tx_sop_q <= PDFR_SOP;
			pre_q <= '0;
			sym_q <= '0;
			bit_q <= '0;
			idx_q <= '0;
			hi_q <= 1'b0;
			byte_q <= '0;
			crc_q <= CRC_PRESET;
			abort_q <= 1'b0;
		end else begin
			tx_st_q <= tx_st_d;
			tx_sop_q <= (tx_st_q == T_IDLE) ? TX_SOP : tx_sop_q;
			pre_q <= pre_d;
			sym_q <= sym_d;
			bit_q <= bit_d;
			idx_q <= idx_d;
			hi_q <= hi_d;
			byte_q <= byte_d;
			crc_q <= crc_d;
			abort_q <= tx_st_d != T_IDLE && (abort_q || TX_ABORT);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			LINE_TX_EN <= 1'b0;
			LINE_TX_STB <= 1'b0;
			LINE_TX_BIT <= 1'b0;
			TX_DONE <= 1'b0;
			TX_REFUSED <= 1'b0;
			TX_CUT <= 1'b0;
		end else begin
			LINE_TX_EN <= tx_st_d != T_IDLE;
			LINE_TX_STB <= stb_d;
			LINE_TX_BIT <= lbit_d;
			TX_DONE <= done_d;
			TX_REFUSED <= TX_START && (tx_st_q != T_IDLE || !tx_ok); // R10 R13 R14
			TX_CUT <= cut_d;
		end
	end

	// ==========================================================
	// receive path
	pdfr_rx_e rx_st_q;
	pdfr_rx_e rx_st_d;
	logic [4:0] sh_q;
	logic [4:0] sh_d;
	logic [2:0] rbit_q;
	logic [2:0] rbit_d;
	logic [1:0] kidx_q;
	logic [1:0] kidx_d;
	logic [19:0] codes_q;
	logic [19:0] codes_d;
	logic [19:0] codes_n;
	logic [31:0] rcrc_q;
	logic [31:0] rcrc_d;
	logic [NW-1:0] nb_q;
	logic [NW-1:0] nb_d;
	logic [NW-1:0] olen_q;
	logic [NW-1:0] olen_d;
	logic [NW-1:0] oidx_q;
	logic [NW-1:0] oidx_d;
	logic [3:0] lo_q;
	logic [3:0] lo_d;
	logic rhi_q;
	logic rhi_d;
	logic rerr_q;
	logic rerr_d;
	pdfr_sop_e rsop_q;
	pdfr_sop_e rsop_d;
	pdfr_sop_e cls;
	logic [4:0] dec;
	logic [7:0] byte_n;
	logic [7:0] mem_q [RX_BYTES];
	logic wr;
	logic good;
	logic rsym_end;
	logic rvalid_d;
	logic rlast_d;
	logic disc_d;
	logic dbg_d;

	assign sh_d = {LINE_RX_BIT, sh_q[4:1]}; // R29
	assign codes_n = {sh_d, codes_q[19:5]};
	assign cls = pdfr_classify(codes_n); // R26
	assign dec = pdfr_dec(sh_d); // R25
	assign byte_n = {dec[3:0], lo_q};
	assign rsym_end = LINE_RX_STB && rbit_q == 3'(SYM_BITS - 1);
	assign good = !rerr_q && !rhi_q && nb_q > NW'(CRC_BYTES) && rcrc_q == CRC_RESIDUAL; // R20 R23

	// hunting aligns on the first sync1 or reset1: a corrupted first code is missed
	always_comb begin
		rx_st_d = rx_st_q;
		rbit_d = rbit_q;
		kidx_d = kidx_q;
		codes_d = codes_q;
		rcrc_d = rcrc_q;
		nb_d = nb_q;
		olen_d = olen_q;
		oidx_d = oidx_q;
		lo_d = lo_q;
		rhi_d = rhi_q;
		rerr_d = rerr_q;
		rsop_d = rsop_q;
		wr = 1'b0;
		rvalid_d = 1'b0;
		rlast_d = 1'b0;
		disc_d = 1'b0;
		dbg_d = 1'b0;
		case (rx_st_q)
			R_HUNT: begin
				if (LINE_RX_ACTIVE && LINE_RX_STB && (sh_d == K_SYNC1 || sh_d == K_RST1)) begin
					rx_st_d = R_SOP;
					rbit_d = '0;
					kidx_d = 2'h1;
					codes_d = codes_n;
				end
			end
			R_SOP, R_DATA: begin
				if (!LINE_RX_ACTIVE) begin
					rx_st_d = R_HUNT;
					disc_d = 1'b1;
				end else if (LINE_RX_STB) begin
					rbit_d = rsym_end ? 3'h0 : rbit_q + 3'h1;
					if (rsym_end && rx_st_q == R_SOP) begin
						codes_d = codes_n;
						kidx_d = kidx_q + 2'h1;
						if (kidx_q == 2'(SOP_LEN - 1)) begin
							rsop_d = cls;
							if (pdfr_accept(CFG, cls)) begin // R9 R11 R12 R13 R14 R15
								rx_st_d = R_DATA;
								rcrc_d = CRC_PRESET; // R21
								nb_d = '0;
								rhi_d = 1'b0;
								rerr_d = 1'b0;
							end else begin
								rx_st_d = R_DROP; // R9 R10
								disc_d = 1'b1;
								dbg_d = cls == PDFR_DBG_P || cls == PDFR_DBG_PP; // R8
							end
						end
					end else if (rsym_end) begin
						if (sh_d == K_EOP) begin
							if (good) begin
								rx_st_d = R_OUT; // R20
								olen_d = nb_q - NW'(CRC_BYTES);
								oidx_d = '0;
							end else begin
								rx_st_d = R_HUNT; // R20 R27
								disc_d = 1'b1;
							end
						end else if (dec[4]) begin
							rerr_d = 1'b1; // R25 R27
						end else if (!rhi_q) begin
							lo_d = dec[3:0];
							rhi_d = 1'b1;
						end else begin
							rhi_d = 1'b0;
							if (nb_q < NW'(RX_BYTES)) begin
								wr = 1'b1;
								nb_d = nb_q + 1'b1;
								rcrc_d = pdfr_crc_byte(rcrc_q, byte_n); // R22
							end else begin
								rerr_d = 1'b1;
							end
						end
					end
				end
			end
			R_DROP: begin
				if (!LINE_RX_ACTIVE) begin
					rx_st_d = R_HUNT;
				end
			end
			default: begin
				rvalid_d = 1'b1;
				rlast_d = oidx_q == olen_q - 1'b1;
				oidx_d = oidx_q + 1'b1;
				if (rlast_d) begin
					rx_st_d = R_HUNT;
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			rx_st_q <= R_HUNT;
			sh_q <= '0;
			rbit_q <= '0;
			kidx_q <= '0;
			codes_q <= '0;
			rcrc_q <= CRC_PRESET;
			nb_q <= '0;
			olen_q <= '0;
			oidx_q <= '0;
			lo_q <= '0;
			rhi_q <= 1'b0;
			rerr_q <= 1'b0;
			rsop_q <= PDFR_NONE;
		end else begin
			rx_st_q <= rx_st_d;
			sh_q <= LINE_RX_STB ? sh_d : sh_q;
			rbit_q <= rbit_d;
			kidx_q <= kidx_d;
			codes_q <= codes_d;
			rcrc_q <= rcrc_d;
			nb_q <= nb_d;
			olen_q <= olen_d;
			oidx_q <= oidx_d;
			lo_q <= lo_d;
			rhi_q <= rhi_d;
			rerr_q <= rerr_d;
			rsop_q <= rsop_d;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (wr) begin
			mem_q[nb_q[AW-1:0]] <= byte_n;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			RX_VALID <= 1'b0;
			RX_DATA <= 8'h00;
			RX_LAST <= 1'b0;
			RX_SOP <= PDFR_NONE;
			RX_DISCARD <= 1'b0;
			RX_DEBUG <= 1'b0;
		end else begin
			RX_VALID <= rvalid_d;
			RX_DATA <= rvalid_d ? mem_q[oidx_q[AW-1:0]] : RX_DATA;
			RX_LAST <= rlast_d;
			RX_SOP <= (rvalid_d || dbg_d) ? rsop_d : RX_SOP; // R28
			RX_DISCARD <= disc_d; // R28
			RX_DEBUG <= dbg_d; // R8
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	AST_PRE_ALTERNATES: assert property ( // R3
		(tx_st_q == T_PRE && bit_en) |=> LINE_TX_STB && LINE_TX_BIT == $past(pre_q[0]))
		else $error("preamble bit does not alternate");
	AST_START_PRESET: assert property ( // R21
		$rose(LINE_TX_EN) |-> tx_st_q == T_PRE && crc_q == CRC_PRESET)
		else $error("frame did not open with preamble and preset");
	AST_CABLE_NO_SOP_TX: assert property ( // R10
		(tx_st_q == T_IDLE && TX_START && CFG.is_cable && TX_SOP == PDFR_SOP) |=> TX_REFUSED && !LINE_TX_EN)
		else $error("cable plug sent an ordinary packet");
	AST_PRIME_BAN_TX: assert property ( // R14
		(tx_st_q == T_IDLE && TX_START && TX_SOP == PDFR_SOP_P && CFG.is_sink && !CFG.contract_explicit)
		|=> TX_REFUSED && !LINE_TX_EN)
		else $error("sink sent single-prime without explicit contract");
	AST_DATA_SYMBOL: assert property ( // R17
		(tx_st_q == T_DATA || tx_st_q == T_CRC) |-> pdfr_dec(sym_q) < 5'h10)
		else $error("payload symbol is not hex data");
	AST_CRC_FIRST_NIBBLE: assert property ( // R18
		$rose(tx_st_q == T_CRC) |-> $past(tx_st_q) == T_DATA && sym_q == DATA_SYM[field_w[3:0]])
		else $error("crc does not follow payload");
	AST_EOP_ENDS: assert property ( // R19
		(tx_st_q == T_EOP && sym_end) |=> tx_st_q == T_TAIL && LINE_TX_EN)
		else $error("end code not closing the frame");
	AST_DELIVER_GOOD: assert property ( // R20
		$rose(rx_st_q == R_OUT) |-> $past(rcrc_q) == CRC_RESIDUAL && !$past(rerr_q) ##1 RX_VALID)
		else $error("delivered packet failed its check");
	AST_CABLE_NO_SOP_RX: assert property ( // R10
		(RX_VALID && CFG.is_cable) |-> RX_SOP != PDFR_SOP)
		else $error("cable plug delivered an ordinary packet");
	AST_DECODE_ERR_DROP: assert property ( // R27
		(rx_st_q == R_DATA && LINE_RX_ACTIVE && rsym_end && sh_d == K_EOP && rerr_q)
		|=> RX_DISCARD && rx_st_q == R_HUNT)
		else $error("packet with bad symbol was not discarded");

	COV_TX_DONE: cover property ($rose(TX_DONE));
	COV_RX_DELIVER: cover property (RX_VALID && RX_LAST);
	COV_RX_DISCARD: cover property (RX_DISCARD);
	COV_TX_REFUSED: cover property (TX_REFUSED);
endmodule : pdfr_packet_framer

// ### pdfr_line_peer.sv
// pdfr_line_peer: far-end port model that records a sent frame and plays it back
module pdfr_line_peer (
	// clock
	input wire logic clk,
	// from the framer
	input wire logic tx_stb,
	input wire logic tx_bit,
	// toward the framer
	output logic rx_active,
	output logic rx_stb,
	output logic rx_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cap[$];
	initial begin
		rx_active = 1'b0;
		rx_stb = 1'b0;
		rx_bit = 1'b0;
	end
	always @(posedge clk) begin
		if (tx_stb === 1'b1) cap.push_back(tx_bit);
	end
	// ==========================================================
	// playback, one bit inverted at index flip (negative: none)
	task automatic play(input int flip);
		foreach (cap[i]) begin
			@(negedge clk);
			rx_active = 1'b1;
			rx_stb = 1'b1;
			rx_bit = cap[i] ^ (i == flip);
			@(negedge clk);
			rx_stb = 1'b0;
			// hold expired: never leave a stale level on the line
			rx_bit = ~rx_bit;
			repeat (3) @(negedge clk);
		end
		rx_active = 1'b0;
	endtask : play
endmodule : pdfr_line_peer

// ### tb_top.sv
// tb_top: self-checking bench for the packet framer
module tb_top import pdfr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, reset = 1'b1, start = 1'b0, valid = 1'b0, last = 1'b0, abort = 1'b0;
	logic [7:0] data = 8'h00;
	pdfr_cfg_s cfg = 7'h18;
	pdfr_sop_e sop = PDFR_SOP;
	logic ready, done, refused, cut, en, stb, bit_o, act, rstb, rbit, rvalid, rlast, disc, dbg;
	logic [7:0] rdata;
	pdfr_sop_e rsop;
	logic rx_end = 1'b0, rx_disc = 1'b0, rx_dbg = 1'b0;
	logic [7:0] rxq[$];
	logic exp_q[$];
	logic [7:0] pay [4] = '{8'hA5, 8'h3C, 8'h00, 8'hFF};
	// start sets, first code in the low bits
	logic [19:0] sets [3] = '{20'h8E318, 20'h31B18, 20'h360D8};
	int n_fail = 0, n_compared = 0;

	pdfr_packet_framer #(.BIT_DIV(4), .RX_BYTES(8)) dut (.CLOCK(clock), .RESET(reset), .CFG(cfg),
		.TX_START(start), .TX_SOP(sop), .TX_ABORT(abort), .TX_DATA(data), .TX_VALID(valid), .TX_LAST(last),
		.TX_READY(ready), .TX_DONE(done), .TX_REFUSED(refused), .TX_CUT(cut), .LINE_TX_EN(en),
		.LINE_TX_STB(stb), .LINE_TX_BIT(bit_o), .LINE_RX_ACTIVE(act), .LINE_RX_STB(rstb), .LINE_RX_BIT(rbit),
		.RX_VALID(rvalid), .RX_DATA(rdata), .RX_LAST(rlast), .RX_SOP(rsop), .RX_DISCARD(disc), .RX_DEBUG(dbg));
	pdfr_line_peer peer (.clk(clock), .tx_stb(stb), .tx_bit(bit_o), .rx_active(act), .rx_stb(rstb),
		.rx_bit(rbit));

	initial forever #5 clock = ~clock;
	always @(negedge clock) begin
		if (rvalid === 1'b1) rxq.push_back(rdata);
		rx_end <= rx_end | rlast | disc;
		rx_disc <= rx_disc | disc;
		rx_dbg <= rx_dbg | dbg;
	end

	// ==========================================================
	// common tasks
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : check

	task automatic test_done;
		if (n_fail == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	task automatic limit(input int k, input int m);
		if (k >= m) begin
			n_fail++;
			test_done();
		end
	endtask : limit

	task automatic put(input logic [4:0] s);
		for (int i = 0; i < 5; i++) exp_q.push_back(s[i]);
	endtask : put

	task automatic send(input pdfr_sop_e t, input int n);
		logic [31:0] c;
		int k;
		c = 32'hFFFFFFFF;
		exp_q.delete();
		peer.cap.delete();
		for (int i = 0; i < 64; i++) exp_q.push_back(i[0]);
		for (int j = 0; j < 20; j++) exp_q.push_back(sets[t][j]);
		for (int b = 0; b < n; b++) begin
			put(DATA_SYM[pay[b][3:0]]);
			put(DATA_SYM[pay[b][7:4]]);
			for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ pay[b][i]) ? 32'hEDB88320 : 32'h0);
			@(negedge clock);
			valid = 1'b1;
			data = pay[b];
			last = (b == n - 1);
		end
		c = ~c;
		for (int j = 0; j < 8; j++) put(DATA_SYM[c[4*j+:4]]);
		put(5'h0D);
		@(negedge clock);
		valid = 1'b0;
		if (n == 4) check(ready, 1'b0);
		start = 1'b1;
		sop = t;
		@(negedge clock);
		start = 1'b0;
		for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge clock);
		limit(k, 3000);
		check(ready, 1'b1);
		check(peer.cap.size(), exp_q.size());
		foreach (exp_q[i]) if (i < peer.cap.size()) check(peer.cap[i], exp_q[i]);
	endtask : send

	task automatic recv(input pdfr_sop_e t, input int n, input int flip, input logic ok);
		int k;
		// cleared away from the monitor's edge so its update cannot race the clear
		@(posedge clock);
		rxq.delete();
		rx_end = 1'b0;
		rx_disc = 1'b0;
		rx_dbg = 1'b0;
		peer.play(flip);
		for (k = 0; k < 200 && rx_end !== 1'b1; k++) @(negedge clock);
		limit(k, 200);
		check(rx_disc, !ok);
		check(rx_dbg, t == PDFR_DBG_P || t == PDFR_DBG_PP);
		check(rxq.size(), ok ? n : 0);
		if (ok || t > PDFR_SOP_PP) check(rsop, t);
		foreach (rxq[i]) if (i < n) check(rxq[i], pay[i]);
	endtask : recv

	// ==========================================================
	// scenarios
	task automatic s_variants;
		for (int i = 0; i < 3; i++) begin
			send(pdfr_sop_e'(i), i == 0 ? 4 : 2);
			recv(pdfr_sop_e'(i), i == 0 ? 4 : 2, -1, 1'b1);
		end
	endtask : s_variants

	task automatic s_bad;
		logic [9:0] tab [3] = '{10'h200, 10'h091, 10'h0A9};
		logic [19:0] dset = {K_SYNC3, K_RST2, K_RST2, K_SYNC1};
		logic r;
		send(PDFR_SOP, 2);
		recv(PDFR_SOP, 2, 69, 1'b1);
		// bit 87 turns the first data symbol into a reserved code
		recv(PDFR_SOP, 2, 87, 1'b0);
		cfg = 7'h40;
		recv(PDFR_SOP, 2, -1, 1'b0);
		for (int j = 0; j < 20; j++) peer.cap[64 + j] = dset[j];
		recv(PDFR_DBG_P, 2, -1, 1'b0);
		foreach (tab[i]) begin
			cfg = tab[i][9:3];
			sop = pdfr_sop_e'(tab[i][2:0]);
			start = 1'b1;
			@(negedge clock);
			start = 1'b0;
			r = refused;
			@(negedge clock);
			check(r, 1'b1);
			check(refused, 1'b0);
			check(en, 1'b0);
		end
	endtask : s_bad

	task automatic s_cut;
		int k;
		cfg = 7'h18;
		sop = PDFR_SOP;
		// pass 0: payload never arrives; pass 1: abort held from the start
		for (int a = 0; a < 2; a++) begin
			peer.cap.delete();
			abort = a[0];
			start = 1'b1;
			@(negedge clock);
			start = 1'b0;
			for (k = 0; k < 3000 && cut !== 1'b1; k++) @(negedge clock);
			limit(k, 3000);
			for (k = 0; k < 100 && en !== 1'b0; k++) @(negedge clock);
			limit(k, 100);
			check(peer.cap.size(), a ? 74 : 89);
			for (int i = 0; i < 5; i++) check(peer.cap[(a ? 69 : 84) + i], K_EOP[i]);
		end
		abort = 1'b0;
	endtask : s_cut

	initial begin
		repeat (16) @(negedge clock);
		reset = 1'b0;
		s_variants();
		s_bad();
		s_cut();
		test_done();
	end
endmodule : tb_top
